// ===== src/rftrc_pkg.sv
// Constants, register map and carrier types of the RF timing control block.
// Assumes a 50 MHz aclk and event strobes from logic on the same clock.
// Operation
// - Delay timer low byte becomes zero at reset, enable low, protocol write.
// - Programmed delay length decides when delayed transmission begins.
// - Delay counts in 590 ns steps, codes 1 to 16383.
// - Delay length all zero means timer disabled, no delay applied.
// - Protocol selection presets delay low byte to zero.
// - Pulse override zero: pulse width comes from selected protocol.
// - Nonzero pulse override: width equals code times 73.7 ns.
// - Pulse override cleared at reset, enable low, protocol write.
// - Protocol choice applies its default modulation pulse width.
// - No response within window: set status flag and raise interrupt.
// - Silence window counts 37.76 us steps from end of transmit EOF.
// - No-response interrupt only while vicinity protocol is selected.
// - Protocol write presets silence wait: 755, 1812 or 529 us.
// - Silence measurement restarts at each anticollision slot start.
// - High byte holds length bits 13..8 and start condition.
// - Start condition selects TX/RX SOF begin or end as start.
package rftrc_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_PROTOCOL = 6'h01;
  localparam logic [5:0] IDX_TX_DELAY_HIGH = 6'h04;
  localparam logic [5:0] IDX_TX_DELAY_LOW = 6'h05;
  localparam logic [5:0] IDX_PULSE_OVERRIDE = 6'h06;
  localparam logic [5:0] IDX_SILENCE_WAIT = 6'h07;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h0C;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0D;
  localparam logic [5:0] IDX_TIMER_STATE = 6'h0E;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_PROTOCOL = 8'h00;
  localparam logic [7:0] RST_TX_DELAY_HIGH = 8'hC2;
  localparam logic [7:0] RST_TX_DELAY_LOW = 8'h00;
  localparam logic [7:0] RST_PULSE_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_SILENCE_WAIT = 8'h0E;
  localparam int START_COND_MSB = 7;
  localparam int START_COND_LSB = 6;
  localparam int LEN_HIGH_MSB = 5;
  localparam int PROTO_MSB = 2;
  localparam int IRQ_SILENCE_BIT = 0;
  localparam int IRQ_DELAY_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Protocol codes and silence presets
  // ************************************************************
  localparam logic [2:0] PROTO_VIC_LOW = 3'h0;
  localparam logic [2:0] PROTO_VIC_HIGH = 3'h1;
  localparam logic [2:0] PROTO_A_106 = 3'h2;
  localparam logic [2:0] PROTO_A_212 = 3'h3;
  localparam logic [2:0] PROTO_A_424 = 3'h4;
  localparam logic [2:0] PROTO_A_848 = 3'h5;
  localparam logic [7:0] SILENCE_VIC_HIGH = 8'h14; // 755 us
  localparam logic [7:0] SILENCE_VIC_LOW = 8'h30; // 1812 us
  localparam logic [7:0] SILENCE_OTHER = 8'h0E; // 529 us

  // ************************************************************
  // Timing, in printed units, and derived cycle counts
  // ************************************************************
  localparam int CLK_PERIOD_PS = 20000;
  localparam int DELAY_STEP_PS = 590000;
  localparam int PULSE_STEP_PS = 73700;
  localparam int SILENCE_STEP_PS = 37760000;
  localparam int PULSE_VIC_PS = 9440000;
  localparam int PULSE_A106_PS = 2360000;
  localparam int PULSE_A212_PS = 1400000;
  localparam int PULSE_A424_PS = 737000;
  localparam int PULSE_A848_PS = 442000;
  // Steps are rounded to the nearest whole cycle
  localparam int DELAY_STEP_CYC =
    (DELAY_STEP_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int SILENCE_STEP_CYC =
    (SILENCE_STEP_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam logic [15:0] PULSE_STEP_CYC =
    16'((PULSE_STEP_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
  localparam logic [15:0] PULSE_VIC_CYC =
    16'((PULSE_VIC_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
  localparam logic [15:0] PULSE_A106_CYC =
    16'((PULSE_A106_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
  localparam logic [15:0] PULSE_A212_CYC =
    16'((PULSE_A212_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
  localparam logic [15:0] PULSE_A424_CYC =
    16'((PULSE_A424_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);
  localparam logic [15:0] PULSE_A848_CYC =
    16'((PULSE_A848_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic {
    RFTRC_IDLE = 1'b0,
    RFTRC_RUN = 1'b1
  } rftrc_timer_state_type;

  // Frame events from the framing logic, one-cycle pulses
  typedef struct packed {
    logic tx_sof_begin;
    logic tx_sof_end;
    logic rx_sof_begin;
    logic rx_sof_end;
    logic tx_eof_end;
    logic slot_begin;
    logic response_begin;
    logic fifo_reset;
    logic mod_request;
  } rftrc_event_type;

endpackage : rftrc_pkg

// ===== src/rftrc_timing.sv
// Delayed-transmission timer, pulse-length control and no-response timer
// with an AXI4-Lite register slave.
// Assumes events arrive as same-clock pulses; the enable pin is async.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module rftrc_timing
  import rftrc_pkg::*;
#(
  parameter logic [15:0] DELAY_STEP_CYCLES = 16'(DELAY_STEP_CYC),
  parameter logic [15:0] SILENCE_STEP_CYCLES = 16'(SILENCE_STEP_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic enable_pin,
  input wire rftrc_event_type events,
  output logic delayed_tx_start,
  output logic mod_pulse,
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [7:0] protocol;
    logic [7:0] tx_delay_high;
    logic [7:0] tx_delay_low;
    logic [7:0] pulse_override;
    logic [7:0] silence_wait_code;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic aw_rdy;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_rdy;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    rftrc_timer_state_type delay_state;
    logic [15:0] delay_pre;
    logic [13:0] delay_cnt;
    logic tx_start;
    rftrc_timer_state_type silence_state;
    logic [15:0] silence_pre;
    logic [7:0] silence_cnt;
    logic mod_active;
    logic [15:0] mod_cnt;
  } rftrc_state_type;

  localparam rftrc_state_type RST_STATE = '{
    en_s1: 1'b0, en_s2: 1'b0, protocol: RST_PROTOCOL,
    tx_delay_high: RST_TX_DELAY_HIGH, tx_delay_low: RST_TX_DELAY_LOW,
    pulse_override: RST_PULSE_OVERRIDE, silence_wait_code: RST_SILENCE_WAIT,
    irq_status: 2'h0, irq_mask: 2'h0, irq: 1'b0,
    aw_rdy: 1'b0, aw_held: 1'b0, aw_idx: 6'h00, w_rdy: 1'b0,
    w_held: 1'b0, w_data: 8'h00, w_lane0: 1'b0, bvalid: 1'b0,
    bresp: RESP_OKAY, ar_rdy: 1'b0, rvalid: 1'b0, rdata: 32'h00000000,
    rresp: RESP_OKAY, delay_state: RFTRC_IDLE, delay_pre: 16'h0000,
    delay_cnt: 14'h0000, tx_start: 1'b0, silence_state: RFTRC_IDLE,
    silence_pre: 16'h0000, silence_cnt: 8'h00, mod_active: 1'b0,
    mod_cnt: 16'h0000};

  rftrc_state_type st;
  rftrc_state_type next_st;

  // Decoded helpers, combinational on the current state and the frame events
  logic vicinity;
  logic [13:0] delay_length;
  logic [1:0] delay_start_condition;
  logic delay_start_hit;
  logic proto_write;
  logic [15:0] pulse_width;

  assign vicinity = (st.protocol[PROTO_MSB:0] == PROTO_VIC_LOW) ||
    (st.protocol[PROTO_MSB:0] == PROTO_VIC_HIGH);
  assign delay_length = {st.tx_delay_high[LEN_HIGH_MSB:0], st.tx_delay_low};
  assign delay_start_condition =
    st.tx_delay_high[START_COND_MSB:START_COND_LSB];
  assign proto_write = st.aw_held && st.w_held && !st.bvalid &&
    st.w_lane0 && (st.aw_idx == IDX_PROTOCOL);

  // Start event chosen by the start-condition field
  always_comb begin
    unique case (delay_start_condition)
      2'b00: delay_start_hit = events.tx_sof_begin;
      2'b01: delay_start_hit = events.tx_sof_end;
      2'b10: delay_start_hit = events.rx_sof_begin;
      2'b11: delay_start_hit = events.rx_sof_end;
    endcase
  end

  // Pulse width: override wins when nonzero, else protocol default
  always_comb begin
    if (st.pulse_override != 8'h00) begin
      pulse_width = 16'(st.pulse_override) * PULSE_STEP_CYC;
    end else begin
      unique case (st.protocol[PROTO_MSB:0])
        PROTO_A_106: pulse_width = PULSE_A106_CYC;
        PROTO_A_212: pulse_width = PULSE_A212_CYC;
        PROTO_A_424: pulse_width = PULSE_A424_CYC;
        PROTO_A_848: pulse_width = PULSE_A848_CYC;
        default: pulse_width = PULSE_VIC_CYC;
      endcase
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [7:0] wd;
    logic [5:0] ridx;
    logic reset_regs;
    logic silence_cancel;
    irq_set = 2'h0;
    irq_clr = 2'h0;
    wd = st.w_data;
    ridx = araddr[7:2];
    reset_regs = 1'b0;
    silence_cancel = 1'b0;
    next_st = st;
    // Enable pin passes two flops before use
    next_st.en_s1 = enable_pin;
    next_st.en_s2 = st.en_s1;
    next_st.tx_start = 1'b0;

    // Write response retires
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (awvalid && st.aw_rdy) begin
      next_st.aw_held = 1'b1;
      next_st.aw_idx = awaddr[7:2];
    end
    if (wvalid && st.w_rdy) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata[7:0];
      next_st.w_lane0 = wstrb[0];
    end

    // Commit a write once address and data are both held
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.w_lane0) begin
        unique case (st.aw_idx)
          IDX_PROTOCOL: next_st.protocol = wd;
          IDX_TX_DELAY_HIGH: next_st.tx_delay_high = wd;
          IDX_TX_DELAY_LOW: next_st.tx_delay_low = wd;
          IDX_PULSE_OVERRIDE: next_st.pulse_override = wd;
          IDX_SILENCE_WAIT: next_st.silence_wait_code = wd;
          IDX_IRQ_STATUS: irq_clr = wd[1:0];
          IDX_IRQ_MASK: next_st.irq_mask = wd[1:0];
          IDX_TIMER_STATE: ;
          default: next_st.bresp = RESP_SLVERR;
        endcase
      end else if (!(st.aw_idx inside {IDX_PROTOCOL, IDX_TX_DELAY_HIGH,
          IDX_TX_DELAY_LOW, IDX_PULSE_OVERRIDE, IDX_SILENCE_WAIT,
          IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_TIMER_STATE})) begin
        next_st.bresp = RESP_SLVERR;
      end
    end

    // Protocol write or enable low loads the timing defaults
    reset_regs = proto_write || !st.en_s2;
    if (reset_regs) begin
      next_st.tx_delay_low = RST_TX_DELAY_LOW;
      next_st.tx_delay_high = RST_TX_DELAY_HIGH;
      next_st.pulse_override = RST_PULSE_OVERRIDE;
      next_st.silence_wait_code = RST_SILENCE_WAIT;
    end
    if (proto_write) begin
      unique case (wd[PROTO_MSB:0])
        PROTO_VIC_HIGH: next_st.silence_wait_code = SILENCE_VIC_HIGH;
        PROTO_VIC_LOW: next_st.silence_wait_code = SILENCE_VIC_LOW;
        default: next_st.silence_wait_code = SILENCE_OTHER;
      endcase
    end

    // Read channel: one outstanding read, data one cycle after address
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (arvalid && st.ar_rdy) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h00000000;
      unique case (ridx)
        IDX_PROTOCOL: next_st.rdata[7:0] = st.protocol;
        IDX_TX_DELAY_HIGH: next_st.rdata[7:0] = st.tx_delay_high;
        IDX_TX_DELAY_LOW: next_st.rdata[7:0] = st.tx_delay_low;
        IDX_PULSE_OVERRIDE: next_st.rdata[7:0] = st.pulse_override;
        IDX_SILENCE_WAIT: next_st.rdata[7:0] = st.silence_wait_code;
        IDX_IRQ_STATUS: next_st.rdata[1:0] = st.irq_status;
        IDX_IRQ_MASK: next_st.rdata[1:0] = st.irq_mask;
        IDX_TIMER_STATE: next_st.rdata[2:0] = {st.mod_active,
          st.silence_state, st.delay_state};
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end

    // Delayed-transmission timer; a new start event reloads it
    if (reset_regs) begin
      next_st.delay_state = RFTRC_IDLE;
    end else if (delay_start_hit) begin
      if (delay_length == 14'h0000) begin
        next_st.tx_start = 1'b1;
        next_st.delay_state = RFTRC_IDLE;
      end else begin
        next_st.delay_state = RFTRC_RUN;
        next_st.delay_pre = 16'h0000;
        next_st.delay_cnt = delay_length;
      end
    end else if (st.delay_state == RFTRC_RUN) begin
      if (st.delay_pre == DELAY_STEP_CYCLES - 16'h0001) begin
        next_st.delay_pre = 16'h0000;
        next_st.delay_cnt = st.delay_cnt - 14'h0001;
        if (st.delay_cnt == 14'h0001) begin
          next_st.tx_start = 1'b1;
          next_st.delay_state = RFTRC_IDLE;
        end
      end else begin
        next_st.delay_pre = st.delay_pre + 16'h0001;
      end
    end
    if (next_st.tx_start) begin
      irq_set[IRQ_DELAY_BIT] = 1'b1;
    end

    // No-response timer; a FIFO reset also stops it
    silence_cancel = reset_regs || events.response_begin ||
      events.fifo_reset || !vicinity;
    if (silence_cancel) begin
      next_st.silence_state = RFTRC_IDLE;
    end else if ((events.tx_eof_end || events.slot_begin) &&
        st.silence_wait_code != 8'h00) begin
      next_st.silence_state = RFTRC_RUN;
      next_st.silence_pre = 16'h0000;
      next_st.silence_cnt = st.silence_wait_code;
    end else if (st.silence_state == RFTRC_RUN) begin
      if (st.silence_pre == SILENCE_STEP_CYCLES - 16'h0001) begin
        next_st.silence_pre = 16'h0000;
        next_st.silence_cnt = st.silence_cnt - 8'h01;
        if (st.silence_cnt == 8'h01) begin
          next_st.silence_state = RFTRC_IDLE;
          irq_set[IRQ_SILENCE_BIT] = 1'b1;
        end
      end else begin
        next_st.silence_pre = st.silence_pre + 16'h0001;
      end
    end

    // Modulation pulse; a new request restarts the width
    if (events.mod_request) begin
      next_st.mod_active = 1'b1;
      next_st.mod_cnt = pulse_width;
    end else if (st.mod_active) begin
      next_st.mod_cnt = st.mod_cnt - 16'h0001;
      if (st.mod_cnt == 16'h0001) begin
        next_st.mod_active = 1'b0;
      end
    end

    // Sticky status: hardware set wins over a write-one clear
    next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    next_st.aw_rdy = !next_st.aw_held && !next_st.bvalid;
    next_st.w_rdy = !next_st.w_held && !next_st.bvalid;
    next_st.ar_rdy = !next_st.rvalid;
  end

  // Single register stage for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs, straight from flops
  // ************************************************************
  assign awready = st.aw_rdy;
  assign wready = st.w_rdy;
  assign bresp = st.bresp;
  assign bvalid = st.bvalid;
  assign arready = st.ar_rdy;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign rvalid = st.rvalid;
  assign delayed_tx_start = st.tx_start;
  assign mod_pulse = st.mod_active;
  assign irq = st.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_proto_write;
    proto_write;
  endsequence

  sequence seq_zero_start;
    delay_start_hit && delay_length == 14'h0000 && st.en_s2 && !proto_write;
  endsequence

  delay_low_clear_a: assert property (
    seq_proto_write |=> st.tx_delay_low == 8'h00)
    else $error("delay low byte not cleared on protocol write");

  delay_zero_a: assert property (
    seq_zero_start |=> delayed_tx_start && st.delay_state == RFTRC_IDLE)
    else $error("zero length did not start at once");

  delay_step_a: assert property (
    st.delay_state == RFTRC_RUN && !delay_start_hit && st.en_s2 &&
    !proto_write && st.delay_pre == DELAY_STEP_CYCLES - 16'h0001
    |=> st.delay_cnt == $past(st.delay_cnt) - 14'h0001)
    else $error("delay step not counted");

  pulse_load_a: assert property (
    events.mod_request && st.pulse_override != 8'h00
    |=> mod_pulse && st.mod_cnt ==
      16'($past(st.pulse_override)) * PULSE_STEP_CYC)
    else $error("override pulse width wrong");

  override_clear_a: assert property (
    !st.en_s2 |=> st.pulse_override == 8'h00)
    else $error("pulse override not cleared while disabled");

  silence_preset_a: assert property (
    seq_proto_write ##0 (st.w_data[PROTO_MSB:0] == PROTO_VIC_HIGH)
    |=> st.silence_wait_code == SILENCE_VIC_HIGH)
    else $error("vicinity high rate preset wrong");

  silence_irq_a: assert property (
    st.silence_state == RFTRC_RUN && st.silence_cnt == 8'h01 &&
    st.silence_pre == SILENCE_STEP_CYCLES - 16'h0001 && st.en_s2 &&
    !proto_write && !events.response_begin && !events.fifo_reset
    |=> st.irq_status[IRQ_SILENCE_BIT] &&
      (irq || !st.irq_mask[IRQ_SILENCE_BIT]))
    else $error("no-response flag not raised");

  vicinity_only_a: assert property (
    st.silence_state == RFTRC_RUN |-> $past(vicinity))
    else $error("no-response timer ran outside vicinity protocol");

  slot_arm_a: assert property (
    events.slot_begin && vicinity && st.en_s2 && !proto_write &&
    !events.response_begin && !events.fifo_reset &&
    st.silence_wait_code != 8'h00
    |=> st.silence_state == RFTRC_RUN &&
      st.silence_cnt == $past(st.silence_wait_code))
    else $error("slot start did not arm no-response timer");

endmodule : rftrc_timing

// ===== tb/rftrc_tag_model.sv
// Behavioural tag that answers a reader frame after a set delay.
// Assumes frame events arrive on the reader block clock.
`timescale 1ns/100ps
module rftrc_tag_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_end,
  input wire logic answer_en,
  input wire logic [7:0] answer_delay,
  output logic response_begin
);
  int cnt;
  // Count from end of reader frame; a silent tag never pulses
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      response_begin <= 1'b0;
    end else if (frame_end && answer_en) begin
      cnt <= answer_delay + 1;
      response_begin <= 1'b0;
    end else begin
      cnt <= (cnt > 0) ? cnt - 1 : 0;
      response_begin <= (cnt == 1);
    end
  end
endmodule : rftrc_tag_model

// ===== tb/test_rf_tx_rx_timing_control.sv
// Self-checking bench for the RF timing control block.
// Assumes the register map and timing constants of rftrc_pkg.
`timescale 1ns/100ps
module test_rf_tx_rx_timing_control
  import rftrc_pkg::*;
;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam int DS = 2;
  localparam int SS = 3;
  logic aclk = 0, aresetn = 0, enable_pin = 0, answer_en = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, d, v;
  logic [3:0] wstrb = 4'hF;
  logic [8:0] ev = '0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, tag_resp;
  wire delayed_tx_start, mod_pulse, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  rftrc_event_type events_w;
  int miscompares = 0, num_checks = 0, cycles = 0;
  int rise, wid, code, len, p, c, i;
  integer seed = 32'hD28DF392;
  // Tag answer is folded into the event bundle
  assign events_w = rftrc_event_type'(ev | {6'h00, tag_resp, 2'h0});
  rftrc_timing #(.DELAY_STEP_CYCLES(16'(DS)),
    .SILENCE_STEP_CYCLES(16'(SS))) i_dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .enable_pin, .events(events_w), .delayed_tx_start, .mod_pulse, .irq);
  rftrc_tag_model i_tag (.aclk, .aresetn,
    .frame_end(events_w.tx_eof_end), .answer_en, .answer_delay(8'h03),
    .response_begin(tag_resp));
  initial forever #10 aclk = ~aclk;
  // Hang guard, well above the longest expected run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  // ************************************************************
  // Tasks and expectations
  // ************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_cyc(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("Error at %0t: cycles %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_cyc
  // Channels released only at the edge that takes them
  task automatic axi_wr(input logic [5:0] idx, input logic [7:0] dat,
                        output logic [1:0] resp);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
      if (aw && awready === 1'b1) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 0;
        wvalid <= 1'b0;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] idx, output logic [31:0] dat,
                        output logic [1:0] resp);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid === 1'b1) begin
        dat = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
      if (arready === 1'b1) arvalid <= 1'b0;
    end
  endtask : axi_rd
  task automatic wr(input logic [5:0] idx, input logic [7:0] dat);
    logic [1:0] rs;
    axi_wr(idx, dat, rs);
  endtask : wr
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] dd;
    logic [1:0] rs;
    axi_rd(idx, dd, rs);
    chk_val(dd, exp);
    chk_val(32'(rs), 32'(RESP_OKAY));
  endtask : rd_chk
  // Pulse events, then time the selected output: rise, and high width except for irq, where the wait stops at the rise
  task automatic meas(input logic [8:0] m, input int sel,
                      output int rs, output int wd);
    int n;
    logic h;
    n = 0;
    rs = 0;
    wd = 0;
    @(posedge aclk);
    ev <= m;
    do begin
      @(posedge aclk);
      ev <= '0;
      #1;
      n++;
      h = (sel == 0) ? delayed_tx_start : (sel == 1) ? mod_pulse : irq;
      if (h === 1'b1 && rs == 0) rs = n;
      if (h === 1'b1) wd++;
    end while (n < 2000 && (rs == 0 || (h === 1'b1 && sel != 2)));
  endtask : meas
  function automatic int exp_pulse(input int pr);
    case (pr)
      2: return int'(PULSE_A106_CYC);
      3: return int'(PULSE_A212_CYC);
      4: return int'(PULSE_A424_CYC);
      5: return int'(PULSE_A848_CYC);
      default: return int'(PULSE_VIC_CYC);
    endcase
  endfunction : exp_pulse
  function automatic logic [7:0] exp_silence(input int pr);
    return (pr == 0) ? SILENCE_VIC_LOW :
           (pr == 1) ? SILENCE_VIC_HIGH : SILENCE_OTHER;
  endfunction : exp_silence
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    enable_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    rd_chk(IDX_TX_DELAY_LOW, 32'h00);
    rd_chk(IDX_PULSE_OVERRIDE, 32'h00);
    rd_chk(IDX_SILENCE_WAIT, 32'h0E);
    axi_rd(6'h3F, d, r);
    chk_val(d | 32'(r), 32'(RESP_SLVERR));
    axi_wr(6'h3F, 8'h55, r);
    chk_val(32'(r), 32'(RESP_SLVERR));
    for (i = 0; i < 3; i++) begin
      v = $random(seed);
      wr(IDX_TX_DELAY_LOW + 6'(i), v[7:0]);
      rd_chk(IDX_TX_DELAY_LOW + 6'(i), {24'h000000, v[7:0]});
    end
    $display("Test reset and access done");
    // Every protocol code, each after dirtying the delay low byte and the pulse override
    for (p = 0; p < 7; p++) begin
      v = $random(seed);
      wr(IDX_TX_DELAY_LOW, v[7:0] | 8'h01);
      wr(IDX_PULSE_OVERRIDE, v[15:8] | 8'h01);
      wr(IDX_PROTOCOL, 8'(p));
      rd_chk(IDX_TX_DELAY_LOW, 32'h00);
      rd_chk(IDX_PULSE_OVERRIDE, 32'h00);
      rd_chk(IDX_SILENCE_WAIT, 32'(exp_silence(p)));
      meas(9'h001, 1, rise, wid);
      chk_cyc(wid, exp_pulse(p));
      code = int'(v[23:16] | 8'h01);
      wr(IDX_PULSE_OVERRIDE, 8'(code));
      meas(9'h001, 1, rise, wid);
      chk_cyc(wid, code * int'(PULSE_STEP_CYC));
    end
    $display("Test protocol presets done");
    // Four start conditions, a high-byte length, then disabled
    for (c = 0; c < 5; c++) begin
      v = $random(seed);
      len = (c == 4) ? 0 : (c == 3) ? 256 + int'(v[7:0]) : int'(v[7:0]);
      wr(IDX_TX_DELAY_HIGH, {2'(c), 6'(len >> 8)});
      wr(IDX_TX_DELAY_LOW, 8'(len));
      meas(9'h100 >> (c % 4), 0, rise, wid);
      chk_cyc(rise, len * DS + 1);
    end
    rd_chk(IDX_IRQ_STATUS, 32'h02);
    $display("Test delay timer done");
    // Expiry on frame end and slot start, tag answer, other protocol, FIFO
    // reset together with frame end
    for (c = 0; c < 5; c++) begin
      v = $random(seed);
      code = 2 + int'(v[2:0]);
      wr(IDX_PROTOCOL, (c == 3) ? 8'(PROTO_A_106) : 8'(c == 2));
      wr(IDX_SILENCE_WAIT, 8'(code));
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_IRQ_STATUS, 8'hFF);
      answer_en <= (c == 2);
      meas((c == 1) ? 9'h008 : (c == 4) ? 9'h012 : 9'h010, 2, rise,
           wid);
      chk_cyc(rise, (c < 2) ? code * SS + 1 : 0);
      rd_chk(IDX_IRQ_STATUS, (c < 2) ? 32'h01 : 32'h00);
    end
    $display("Test no-response timer done");
    wr(IDX_TX_DELAY_LOW, 8'hA5);
    wr(IDX_PULSE_OVERRIDE, 8'h5A);
    wr(IDX_SILENCE_WAIT, 8'h33);
    @(posedge aclk);
    enable_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    enable_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    rd_chk(IDX_TX_DELAY_LOW, 32'h00);
    rd_chk(IDX_PULSE_OVERRIDE, 32'h00);
    rd_chk(IDX_SILENCE_WAIT, 32'h0E);
    rd_chk(IDX_TIMER_STATE, 32'h00);
    $display("Test enable low done");
    finish_test();
  end
endmodule : test_rf_tx_rx_timing_control
